// ===== src/clk_gate_pkg.sv
/*
  Constants and carrier types for the output control and lock-detect gating block.
  Assumes an 8-bit register port with a 10-bit address, and a single 100 MHz core clock.
*/
`default_nettype none

package clk_gate_pkg;

  // ==========================================================
  // sizes
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int NUM_OUT = 12;
  localparam int NUM_CTRL = 6;
  localparam int NUM_LOW_GATE = 8;
  localparam int NUM_HIGH_GATE = 4;
  localparam int SYNC_STAGES = 2;
  localparam int CLK_PERIOD_NS = 10;

  // ==========================================================
  // register offsets
  localparam logic [9:0] OUT6_CTRL_OFS = 10'h0F6;
  localparam logic [9:0] CLOCK_OUTPUT_SEVEN_CTRL_OFS = 10'h0F7;
  localparam logic [9:0] OUT8_CTRL_OFS = 10'h0F8;
  localparam logic [9:0] OUT9_CTRL_OFS = 10'h0F9;
  localparam logic [9:0] OUT10_CTRL_OFS = 10'h0FA;
  localparam logic [9:0] CLOCK_OUTPUT_ELEVEN_CTRL_OFS = 10'h0FB;
  localparam logic [9:0] GATE_LOW_OFS = 10'h0FC;
  localparam logic [9:0] GATE_HIGH_OFS = 10'h0FD;
  localparam logic [9:0] STAT_LOCK_OFS = 10'h3F0;
  localparam logic [9:0] STAT_EN_LOW_OFS = 10'h3F1;
  localparam logic [9:0] STAT_EN_HIGH_OFS = 10'h3F2;
  localparam logic [9:0] STAT_GATED_LOW_OFS = 10'h3F3;
  localparam logic [9:0] STAT_GATED_HIGH_OFS = 10'h3F4;

  // ==========================================================
  // field positions of an output control byte
  localparam int FMT_BIT = 7;
  localparam int CMOS_MSB = 6;
  localparam int CMOS_LSB = 5;
  localparam int POL_MSB = 4;
  localparam int POL_LSB = 3;
  localparam int SWING_MSB = 2;
  localparam int SWING_LSB = 1;
  localparam int PECL_PD_BIT = 0;
  localparam int LOCK_STAT_BIT = 0;

  // ==========================================================
  // reset values and masks
  localparam logic [7:0] OUT_CTRL_RESET = 8'h64;
  localparam logic [7:0] GATE_LOW_RESET = 8'h00;
  localparam logic [7:0] GATE_HIGH_RESET = 8'h00;
  localparam logic [7:0] GATE_HIGH_MASK = 8'h0F;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ==========================================================
  // output control byte, msb first as laid out in the register
  typedef struct packed {
    logic fmt_cmos;
    logic [1:0] cmos_cfg;
    logic [1:0] polarity;
    logic [1:0] swing;
    logic pecl_pd;
  } out_ctrl_t;

  // register port request
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wr_data;
    logic wr_stb;
    logic rd_stb;
  } reg_req_t;

endpackage

`default_nettype wire

// ===== src/output_gate_cell.sv
/*
  Combinational power-down gating of a group of clock outputs by the lock detect level.
  Assumes the caller supplies the gate mask and the other power-down causes; no clock here.
*/
`default_nettype none

module output_gate_cell #(
  parameter int N = 12
) (
  input wire logic [N-1:0] gate_enable,
  input wire logic lock_detect_gate_signal,
  input wire logic [N-1:0] power_down,
  output logic [N-1:0] gated_off,
  output logic [N-1:0] output_enable
);

  // ==========================================================
  // gating
  // a gated output drops as soon as lock falls, with no clock in the path
  assign gated_off = gate_enable & {N{~lock_detect_gate_signal}};
  // clear gate bit leaves only the other settings in charge
  assign output_enable = ~power_down & ~gated_off;

endmodule // output_gate_cell

`default_nettype wire

// ===== src/output_lock_detect_gating.sv
/*
  Control registers of outputs six to eleven and lock-detect gating of all twelve outputs.
  Assumes a same-clock register master that never issues a read and write together, and
  that the lock detect level arrives asynchronously from the lock detector.
*/
// Function
// - outputs six to eleven: 8-bit control, output-zero layout
// - gate bit clear: output ignores lock level
// - gate bit set: lock low powers down asynchronously
// - high gate bits three to zero gate eight-eleven
`default_nettype none

module output_lock_detect_gating (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire clk_gate_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rd_data,
  input wire logic lock_detect_gate_signal,
  input wire logic [5:0] low_power_down,
  output clk_gate_pkg::out_ctrl_t [5:0] high_out_ctrl,
  output logic [11:0] clock_output_enable
);

  import clk_gate_pkg::*;

  // ==========================================================
  // decode helpers
  // index of an output control register, or NUM_CTRL when not one
  function automatic logic [2:0] ctrl_index(input logic [9:0] addr);
    logic [2:0] idx;
    idx = 3'(NUM_CTRL);
    unique case (addr)
      OUT6_CTRL_OFS: idx = 3'h0;
      CLOCK_OUTPUT_SEVEN_CTRL_OFS: idx = 3'h1;
      OUT8_CTRL_OFS: idx = 3'h2;
      OUT9_CTRL_OFS: idx = 3'h3;
      OUT10_CTRL_OFS: idx = 3'h4;
      CLOCK_OUTPUT_ELEVEN_CTRL_OFS: idx = 3'h5;
      default: idx = 3'(NUM_CTRL);
    endcase
    return idx;
  endfunction

  // true when the index names a real control register
  function automatic logic ctrl_hit(input logic [2:0] idx);
    return idx < 3'(NUM_CTRL);
  endfunction

  // ==========================================================
  // state
  logic [7:0] ctrl_reg [NUM_CTRL];
  logic [7:0] ctrl_next [NUM_CTRL];
  logic [7:0] gate_low_reg;
  logic [7:0] gate_low_next;
  logic [7:0] gate_high_reg;
  logic [7:0] gate_high_next;
  logic lock_sync1_reg;
  logic lock_sync2_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;

  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic [11:0] gate_mask;
  logic [11:0] other_pd;
  logic [11:0] live_gated_off;
  logic [11:0] stat_enable;
  logic [11:0] stat_gated_off;

  assign wr_idx = ctrl_index(reg_req.addr);
  assign rd_idx = ctrl_index(reg_req.addr);

  // ==========================================================
  // control and gate register writes
  always_comb begin
    for (int i = 0; i < NUM_CTRL; i++) begin
      ctrl_next[i] = ctrl_reg[i];
    end
    gate_low_next = gate_low_reg;
    gate_high_next = gate_high_reg;
    if (reg_req.wr_stb) begin
      if (ctrl_hit(wr_idx)) begin
        ctrl_next[wr_idx] = reg_req.wr_data;
      end
      if (reg_req.addr == GATE_LOW_OFS) begin
        gate_low_next = reg_req.wr_data;
      end
      // upper nibble has no storage, so writes there are dropped
      if (reg_req.addr == GATE_HIGH_OFS) begin
        gate_high_next = reg_req.wr_data & GATE_HIGH_MASK;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CTRL; i++) begin
        ctrl_reg[i] <= OUT_CTRL_RESET;
      end
      gate_low_reg <= GATE_LOW_RESET;
      gate_high_reg <= GATE_HIGH_RESET;
    end else begin
      for (int i = 0; i < NUM_CTRL; i++) begin
        ctrl_reg[i] <= ctrl_next[i];
      end
      gate_low_reg <= gate_low_next;
      gate_high_reg <= gate_high_next;
    end
  end

  // ==========================================================
  // control bytes to the output drivers
  always_comb begin
    for (int i = 0; i < NUM_CTRL; i++) begin
      high_out_ctrl[i] = out_ctrl_t'(ctrl_reg[i]);
    end
  end

  // ==========================================================
  // gating of all twelve outputs
  // bit i of the combined mask gates output i
  assign gate_mask = {gate_high_reg[NUM_HIGH_GATE-1:0], gate_low_reg};

  // outputs six to eleven also power down through their own bit
  always_comb begin
    other_pd[5:0] = low_power_down;
    for (int i = 0; i < NUM_CTRL; i++) begin
      other_pd[NUM_CTRL+i] = ctrl_reg[i][PECL_PD_BIT];
    end
  end

  // live path takes the raw pin: power-down must not wait for a clock
  output_gate_cell #(
    .N(NUM_OUT)
  ) live_gate (
    .gate_enable(gate_mask),
    .lock_detect_gate_signal(lock_detect_gate_signal),
    .power_down(other_pd),
    .gated_off(live_gated_off),
    .output_enable(clock_output_enable)
  );

  // ==========================================================
  // lock level synchroniser for readback only
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_sync1_reg <= 1'b0;
      lock_sync2_reg <= 1'b0;
    end else begin
      lock_sync1_reg <= lock_detect_gate_signal;
      lock_sync2_reg <= lock_sync1_reg;
    end
  end

  // status copy from the synchronised level; lags the live path by two clocks
  output_gate_cell #(
    .N(NUM_OUT)
  ) stat_gate (
    .gate_enable(gate_mask),
    .lock_detect_gate_signal(lock_sync2_reg),
    .power_down(other_pd),
    .gated_off(stat_gated_off),
    .output_enable(stat_enable)
  );

  // ==========================================================
  // readback
  // unmapped addresses and idle cycles return zero
  always_comb begin
    rd_data_next = READ_ZERO;
    if (reg_req.rd_stb) begin
      if (ctrl_hit(rd_idx)) begin
        rd_data_next = ctrl_reg[rd_idx];
      end else begin
        unique case (reg_req.addr)
          GATE_LOW_OFS: rd_data_next = gate_low_reg;
          GATE_HIGH_OFS: rd_data_next = gate_high_reg & GATE_HIGH_MASK;
          STAT_LOCK_OFS: rd_data_next = {7'h00, lock_sync2_reg};
          STAT_EN_LOW_OFS: rd_data_next = stat_enable[7:0];
          STAT_EN_HIGH_OFS: rd_data_next = {4'h0, stat_enable[11:8]};
          STAT_GATED_LOW_OFS: rd_data_next = stat_gated_off[7:0];
          STAT_GATED_HIGH_OFS: rd_data_next = {4'h0, stat_gated_off[11:8]};
          default: rd_data_next = READ_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_reg <= READ_ZERO;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign reg_rd_data = rd_data_reg;

endmodule // output_lock_detect_gating

`default_nettype wire

// ===== bench/output_lock_detect_gating_properties.sv
/* checker of the lock gating block, seeing only its ports.
   assumes the package is compiled first; bound below. */
`default_nettype none
module gating_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire clk_gate_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rd_data,
  input wire logic lock_detect_gate_signal,
  input wire logic [5:0] low_power_down,
  input wire clk_gate_pkg::out_ctrl_t [5:0] high_out_ctrl,
  input wire logic [11:0] clock_output_enable
);
  import clk_gate_pkg::*;
  logic [11:0] gate_reg;
  logic [11:0] pd;
  // ==========================================
  // shadow gate bits: not visible at the ports
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b)
      gate_reg <= 12'h000;
    else if (reg_req.wr_stb && reg_req.addr == GATE_LOW_OFS)
      gate_reg[7:0] <= reg_req.wr_data;
    else if (reg_req.wr_stb && reg_req.addr == GATE_HIGH_OFS)
      gate_reg[11:8] <= reg_req.wr_data[3:0]; // upper bits dropped
  end
  // other power-down causes per output
  always_comb begin
    pd[5:0] = low_power_down;
    for (int k = 0; k < 6; k++) pd[k + 6] = high_out_ctrl[k].pecl_pd;
  end
  // ==========================================
  // properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_gate_off: assert property (
    (clock_output_enable & gate_reg & ~{12{lock_detect_gate_signal}}) == 12'h000)
    else $error("gated output on while lock low");
  a_ungated_follow: assert property (
    ((clock_output_enable ^ ~pd) & ~gate_reg) == 12'h000)
    else $error("ungated output disturbed");
  a_locked_on: assert property (
    lock_detect_gate_signal |-> clock_output_enable == ~pd)
    else $error("output off while locked");
  a_ctrl_write: assert property (
    reg_req.wr_stb && reg_req.addr == CLOCK_OUTPUT_ELEVEN_CTRL_OFS |=>
    high_out_ctrl[5] == $past(reg_req.wr_data))
    else $error("control write lost");
  a_ctrl_read: assert property (
    reg_req.rd_stb && reg_req.addr == OUT6_CTRL_OFS |=>
    reg_rd_data == $past(high_out_ctrl[0]))
    else $error("control readback wrong");
  a_low_read: assert property (
    reg_req.rd_stb && reg_req.addr == GATE_LOW_OFS |=> reg_rd_data == $past(gate_reg[7:0]))
    else $error("low gate readback wrong");
  a_unused_zero: assert property (
    reg_req.rd_stb && reg_req.addr == GATE_HIGH_OFS |=>
    reg_rd_data == {4'h0, $past(gate_reg[11:8])})
    else $error("high gate readback wrong");
  c_gated_off: cover property (gate_reg != 12'h000 && !lock_detect_gate_signal);
  c_high_write: cover property (reg_req.wr_stb && reg_req.addr == GATE_HIGH_OFS);
  c_ctrl_read: cover property (reg_req.rd_stb && reg_req.addr == OUT6_CTRL_OFS);
endmodule // gating_checker

bind output_lock_detect_gating gating_checker i_chk (.core_clk, .rst_b, .reg_req,
  .reg_rd_data, .lock_detect_gate_signal, .low_power_down, .high_out_ctrl,
  .clock_output_enable);
`default_nettype wire

// ===== bench/tb_output_lock_detect_gating.sv
/* self-checking bench of the lock gating block against a bench model.
   assumes package, design and checker are compiled before it. */
`default_nettype none
module tb_output_lock_detect_gating import clk_gate_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  reg_req_t reg_req = '0;
  logic [7:0] reg_rd_data;
  logic lock_detect_gate_signal = 1'b0;
  logic [5:0] low_power_down = 6'h00;
  out_ctrl_t [5:0] high_out_ctrl;
  logic [11:0] clock_output_enable;
  int miscompares = 0;
  int num_checks = 0;
  int ctrl_m[6] = '{default: OUT_CTRL_RESET};
  int gate_m = 0;
  int addr_q[$] = '{OUT6_CTRL_OFS, CLOCK_OUTPUT_SEVEN_CTRL_OFS, OUT8_CTRL_OFS, OUT9_CTRL_OFS,
    OUT10_CTRL_OFS, CLOCK_OUTPUT_ELEVEN_CTRL_OFS, GATE_LOW_OFS, GATE_HIGH_OFS, 10'h100,
    STAT_LOCK_OFS, STAT_EN_LOW_OFS, STAT_EN_HIGH_OFS,
    STAT_GATED_LOW_OFS, STAT_GATED_HIGH_OFS};
  int a;
  // ==========================================
  // clock and design
  always #5 core_clk = ~core_clk;
  output_lock_detect_gating i_dut (.core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req),
    .reg_rd_data(reg_rd_data), .lock_detect_gate_signal(lock_detect_gate_signal),
    .low_power_down(low_power_down), .high_out_ctrl(high_out_ctrl),
    .clock_output_enable(clock_output_enable));
  // ==========================================
  // model and shared tasks
  function automatic logic [11:0] exp_en();
    logic [11:0] e;
    for (int i = 0; i < 12; i++) begin
      e[i] = !(i < 6 ? low_power_down[i] : ctrl_m[i % 6][0]);
      if (gate_m[i] && !lock_detect_gate_signal) e[i] = 1'b0; // async power-down
    end
    return e;
  endfunction
  // status view assumes the lock level has stood for at least two clocks
  function automatic int exp_rd(int x);
    logic [11:0] e;
    logic [11:0] g;
    e = exp_en();
    g = 12'(gate_m) & {12{!lock_detect_gate_signal}};
    if (x >= OUT6_CTRL_OFS && x <= CLOCK_OUTPUT_ELEVEN_CTRL_OFS) return ctrl_m[x - OUT6_CTRL_OFS];
    if (x == GATE_LOW_OFS) return gate_m[7:0];
    if (x == GATE_HIGH_OFS) return gate_m[11:8];
    if (x == STAT_LOCK_OFS) return int'(lock_detect_gate_signal);
    if (x == STAT_EN_LOW_OFS) return e[7:0];
    if (x == STAT_EN_HIGH_OFS) return e[11:8];
    if (x == STAT_GATED_LOW_OFS) return g[7:0];
    if (x == STAT_GATED_HIGH_OFS) return g[11:8];
    return 0;
  endfunction
  task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(int x, int d);
    @(posedge core_clk);
    reg_req <= '{addr: x[9:0], wr_data: d[7:0], wr_stb: 1'b1, rd_stb: 1'b0};
    @(posedge core_clk);
    reg_req.wr_stb <= 1'b0;
    if (x >= OUT6_CTRL_OFS && x <= CLOCK_OUTPUT_ELEVEN_CTRL_OFS) ctrl_m[x - OUT6_CTRL_OFS] = d[7:0];
    if (x == GATE_LOW_OFS) gate_m[7:0] = d[7:0];
    if (x == GATE_HIGH_OFS) gate_m[11:8] = d[3:0]; // upper nibble has no storage
  endtask
  task automatic rd(int x);
    @(posedge core_clk);
    reg_req <= '{addr: x[9:0], wr_data: 8'h00, wr_stb: 1'b0, rd_stb: 1'b1};
    @(posedge core_clk);
    reg_req.rd_stb <= 1'b0;
    @(negedge core_clk);
    chk("read data", 12'(exp_rd(x)), {4'h0, reg_rd_data});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================
  // watchdog: a hang counts as a mismatch
  initial begin
    #50000;
    miscompares++;
    tally_and_finish();
  end
  // main sequence: reset values, then random traffic with lock toggling
  initial begin
    void'($urandom(27056));
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (addr_q[k]) rd(addr_q[k]);
    repeat (60) begin
      a = addr_q[$urandom_range(addr_q.size() - 1)];
      wr(a, $urandom);
      rd(a);
      @(posedge core_clk);
      lock_detect_gate_signal <= 1'($urandom_range(1));
      low_power_down <= 6'($urandom);
      @(negedge core_clk);
      chk("enable", exp_en(), clock_output_enable);
      foreach (ctrl_m[k]) chk("control", 12'(ctrl_m[k]), {4'h0, high_out_ctrl[k]});
    end
    tally_and_finish();
  end
endmodule // tb_output_lock_detect_gating
`default_nettype wire
